// ### core/tx_abort_cause.sv
// Transmit abort cause flags with register port and interrupt
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tx_abort_cause #(
    parameter int CW = abort_pkg::CNT_W
) (
    input  wire logic                        CLK,
    input  wire logic                        RST,
    input  wire logic [abort_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [abort_pkg::DATA_W-1:0] WR_DATA,
    input  wire logic                        WR_EN,
    input  wire logic                        RD_EN,
    output logic      [abort_pkg::DATA_W-1:0] RD_DATA,
    input  wire logic                        SLV_TX_ACTIVE,
    input  wire logic                        MST_ACTIVE,
    input  wire logic                        BUS_MISMATCH,
    input  wire logic                        SLV_RD_REQ,
    input  wire logic                        TXFIFO_EMPTY,
    input  wire logic                        MST_START,
    input  wire logic                        MST_RD,
    input  wire logic                        ADDR_10BIT,
    output logic                             MASTER_EN,
    output logic                             RESTART_EN,
    output logic                             TX_ABORT,
    output logic                             TXFIFO_FLUSH,
    output logic                             IRQ
);
    import abort_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [CFG_N-1:0]  cfg;
        logic [INT_N-1:0]  int_en;
        logic [CW-1:0]     abort_cnt;
        logic              abort_evt;
        logic              flush;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [CAUSE_N-1:0] cause_set;
    logic [CAUSE_N-1:0] cause_clr;
    logic [CAUSE_N-1:0] cause_q;
    logic [INT_N-1:0]   int_set;
    logic [INT_N-1:0]   int_clr;
    logic [INT_N-1:0]   int_q;
    logic               any_set;
    logic               stale_rd;
    logic               arb_loss_slv;
    logic               arb_loss_mst;
    logic               wr_abort_clr;
    logic [DATA_W-1:0]  cause_word;

    ////////////////////////////////////////////////////////////////////
    // Cause detection

    // Slave side loss is checked first so the slave case is never
    // reported as a plain master loss
    assign arb_loss_slv = SLV_TX_ACTIVE & BUS_MISMATCH;
    assign arb_loss_mst = MST_ACTIVE & ~SLV_TX_ACTIVE & BUS_MISMATCH;
    assign stale_rd     = SLV_RD_REQ & ~TXFIFO_EMPTY;

    always_comb begin
        cause_set = '0;
        cause_set[BIT_SLV_LOST - CAUSE_LSB]    = arb_loss_slv;
        cause_set[BIT_ARBITRATION_LOST_FLAG - CAUSE_LSB]    =
            arb_loss_slv | arb_loss_mst;
        cause_set[BIT_STALE_FLUSH - CAUSE_LSB] = stale_rd;
        cause_set[BIT_MST_DIS - CAUSE_LSB]     =
            MST_START & ~st_r.cfg[CFG_MASTER_EN];
        cause_set[BIT_WIDE_RD - CAUSE_LSB]     =
            MST_START & st_r.cfg[CFG_MASTER_EN]
            & ~st_r.cfg[CFG_RESTART_EN] & ADDR_10BIT & MST_RD;
    end

    assign any_set      = |cause_set;
    assign wr_abort_clr = WR_EN && (ADDR == OFF_ABORT_CLR);
    assign cause_clr    = {CAUSE_N{wr_abort_clr}};

    // Causes stay readable until software clears the abort
    sticky_bits #(
        .W   (CAUSE_N)
    ) u_cause (
        .CLK (CLK),
        .RST (RST),
        .SET (cause_set),
        .CLR (cause_clr),
        .Q   (cause_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Interrupt status

    always_comb begin
        int_set            = '0;
        int_set[INT_ABORT] = any_set;
        int_set[INT_FLUSH] = any_set;
        int_clr            = '0;
        if (WR_EN && (ADDR == OFF_INT_CLEAR)) begin
            int_clr = WR_DATA[INT_N-1:0];
        end
    end

    sticky_bits #(
        .W   (INT_N)
    ) u_int (
        .CLK (CLK),
        .RST (RST),
        .SET (int_set),
        .CLR (int_clr),
        .Q   (int_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Register port and control

    always_comb begin
        cause_word = '0;
        cause_word[CAUSE_LSB +: CAUSE_N] = cause_q;
    end

    always_comb begin
        st_nxt = st_r;

        // Abort event level; a new cause in the clearing cycle wins
        st_nxt.abort_evt = (st_r.abort_evt & ~wr_abort_clr) | any_set;

        // Every abort discards the old FIFO contents
        st_nxt.flush = any_set;

        if (any_set) begin
            st_nxt.abort_cnt = st_r.abort_cnt + 1'b1;
        end

        if (WR_EN) begin
            case (ADDR)
                OFF_CONFIG: begin
                    st_nxt.cfg = WR_DATA[CFG_N-1:0];
                end
                OFF_INT_ENABLE: begin
                    st_nxt.int_en = WR_DATA[INT_N-1:0];
                end
                OFF_ABORT_CNT: begin
                    st_nxt.abort_cnt = '0;
                end
                default: begin
                end
            endcase
        end

        // Read data stand only in the cycle after the strobe
        st_nxt.rdata = '0;
        if (RD_EN) begin
            case (ADDR)
                OFF_CAUSE: begin
                    st_nxt.rdata = cause_word;
                end
                OFF_CONFIG: begin
                    st_nxt.rdata[CFG_N-1:0] = st_r.cfg;
                end
                OFF_INT_STATUS: begin
                    st_nxt.rdata[INT_N-1:0] = int_q;
                end
                OFF_INT_ENABLE: begin
                    st_nxt.rdata[INT_N-1:0] = st_r.int_en;
                end
                OFF_ABORT_CNT: begin
                    st_nxt.rdata[CW-1:0] = st_r.abort_cnt;
                end
                default: begin
                    st_nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r.cfg       <= CFG_RESET;
            st_r.int_en    <= INT_EN_RESET;
            st_r.abort_cnt <= CW'(0);
            st_r.abort_evt <= 1'b0;
            st_r.flush     <= 1'b0;
            st_r.rdata     <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign RD_DATA      = st_r.rdata;
    assign MASTER_EN    = st_r.cfg[CFG_MASTER_EN];
    assign RESTART_EN   = st_r.cfg[CFG_RESTART_EN];
    assign TX_ABORT     = st_r.abort_evt;
    assign TXFIFO_FLUSH = st_r.flush;
    assign IRQ          = |(int_q & st_r.int_en);
endmodule
`default_nettype wire

// ### common/abort_pkg.sv
// Constants shared by the transmit abort cause block
package abort_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_CAUSE      = 8'h00;
    localparam logic [7:0] OFF_ABORT_CLR  = 8'h04;
    localparam logic [7:0] OFF_CONFIG     = 8'h08;
    localparam logic [7:0] OFF_INT_STATUS = 8'h0c;
    localparam logic [7:0] OFF_INT_CLEAR  = 8'h10;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h14;
    localparam logic [7:0] OFF_ABORT_CNT  = 8'h18;

    // Cause field: bits 10..14 of the cause register
    localparam int CAUSE_LSB       = 10;
    localparam int CAUSE_N         = 5;
    localparam int BIT_WIDE_RD     = 10;
    localparam int BIT_MST_DIS     = 11;
    localparam int BIT_ARBITRATION_LOST_FLAG    = 12;
    localparam int BIT_STALE_FLUSH = 13;
    localparam int BIT_SLV_LOST    = 14;
    localparam logic [CAUSE_N-1:0] CAUSE_RESET = 5'h00;

    // Controller configuration bits
    localparam int CFG_N          = 2;
    localparam int CFG_MASTER_EN  = 0;
    localparam int CFG_RESTART_EN = 1;
    localparam logic [CFG_N-1:0] CFG_RESET = 2'h3;

    // Interrupt status bits
    localparam int INT_N     = 2;
    localparam int INT_ABORT = 0;
    localparam int INT_FLUSH = 1;
    localparam logic [INT_N-1:0] INT_EN_RESET = 2'h0;

    // Abort event counter
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

endpackage

// ### core/sticky_bits.sv
// Sticky flag bank: hardware sets, software clears, set wins
`timescale 1ns/1ps
`default_nettype none
module sticky_bits #(
    parameter int W = 1
) (
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic [W-1:0] SET,
    input  wire logic [W-1:0] CLR,
    output logic      [W-1:0] Q
);
    typedef struct packed {
        logic [W-1:0] flags;
    } sticky_t;

    sticky_t st_r;
    sticky_t st_nxt;

    always_comb begin
        st_nxt       = st_r;
        // A set in the clearing cycle must not be lost
        st_nxt.flags = (st_r.flags & ~CLR) | SET;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign Q = st_r.flags;
endmodule
`default_nettype wire

// ### verif/tx_abort_cause_monitor.sv
// Port-level checker for the abort cause block
`timescale 1ns/1ps
`default_nettype none
module tx_abort_cause_monitor (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [7:0]  ADDR,
    input wire logic        WR_EN,
    input wire logic        RD_EN,
    input wire logic [31:0] RD_DATA,
    input wire logic        SLV_TX_ACTIVE,
    input wire logic        MST_ACTIVE,
    input wire logic        BUS_MISMATCH,
    input wire logic        SLV_RD_REQ,
    input wire logic        TXFIFO_EMPTY,
    input wire logic        MST_START,
    input wire logic        MST_RD,
    input wire logic        ADDR_10BIT,
    input wire logic        MASTER_EN,
    input wire logic        RESTART_EN,
    input wire logic        TX_ABORT,
    input wire logic        TXFIFO_FLUSH,
    input wire logic        IRQ
);
    import abort_pkg::*;
    logic wide;
    logic ev;
    logic clr;
    assign wide = MST_START & MASTER_EN & ~RESTART_EN & ADDR_10BIT & MST_RD;
    assign ev = BUS_MISMATCH & (SLV_TX_ACTIVE | MST_ACTIVE) | SLV_RD_REQ & ~TXFIFO_EMPTY
        | MST_START & ~MASTER_EN | wide;
    assign clr = WR_EN & (ADDR == OFF_ABORT_CLR);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////
    a_slave_lost: assert property (SLV_TX_ACTIVE && BUS_MISMATCH |=> TX_ABORT)
        else $error("slave bus loss gave no abort");
    a_stale_flush: assert property (SLV_RD_REQ && !TXFIFO_EMPTY |=> TXFIFO_FLUSH)
        else $error("stale read gave no flush");
    a_flush_cause: assert property (!ev |=> !TXFIFO_FLUSH)
        else $error("flush without cause");
    a_master_lost: assert property (MST_ACTIVE && BUS_MISMATCH |=> TX_ABORT)
        else $error("master loss gave no abort");
    a_master_dis: assert property (MST_START && !MASTER_EN |=> TX_ABORT)
        else $error("disabled start gave no abort");
    a_wide_read: assert property (wide |=> TX_ABORT ##1 TX_ABORT)
        else $error("wide read gave no abort");
    a_abort_held: assert property (TX_ABORT && !clr |=> TX_ABORT)
        else $error("abort dropped without clear");
    a_abort_clear: assert property (clr && !ev |=> !TX_ABORT)
        else $error("abort survived clear");
    a_read_idle: assert property (!RD_EN |=> RD_DATA == 32'h0)
        else $error("read data outside read slot");
    cover property (ev && !TX_ABORT);
    cover property (clr && TX_ABORT);
    cover property (IRQ);
endmodule
bind tx_abort_cause tx_abort_cause_monitor tx_abort_cause_monitor_i (.CLK, .RST, .ADDR,
    .WR_EN, .RD_EN, .RD_DATA, .SLV_TX_ACTIVE, .MST_ACTIVE, .BUS_MISMATCH, .SLV_RD_REQ,
    .TXFIFO_EMPTY, .MST_START, .MST_RD, .ADDR_10BIT, .MASTER_EN, .RESTART_EN, .TX_ABORT,
    .TXFIFO_FLUSH, .IRQ);
`default_nettype wire

// ### verif/remote_party.sv
// Remote bus party: contends the data line or addresses the device for a read
`timescale 1ns/1ps
`default_nettype none
module remote_party (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic LOSE,
    input  wire logic READ,
    output logic      BUS_MISMATCH,
    output logic      SLV_RD_REQ
);
    // Registered copies of the commands, one clock after them
    always_ff @(posedge CLK) begin
        BUS_MISMATCH <= LOSE & ~RST;
        SLV_RD_REQ   <= READ & ~RST;
    end
endmodule
`default_nettype wire

// ### verif/tx_abort_cause_tb_top.sv
// Self-checking bench for the abort cause block
`timescale 1ns/1ps
`default_nettype none
module tx_abort_cause_tb_top;
    import abort_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, lose = 0, rreq = 0, start = 0;
    logic slv = 0, mst = 0, empty = 1, mrd = 0, a10 = 0, mis, sreq;
    logic men, ren, abrt, flush, irq;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [9:0] s;
    int error_cnt = 0, n_tests = 0, nf, nab = 0;
    // Cfg[9:8] slv mst empty mrd a10 lose rreq start
    localparam logic [9:0] STIM [8] = '{10'h3a4, 10'h302, 10'h322, 10'h364,
                                        10'h221, 10'h139, 10'h339, 10'h129};
    localparam logic [4:0] EXP [8] = '{5'h14, 5'h08, 5'h00, 5'h04,
                                       5'h02, 5'h01, 5'h00, 5'h00};
    always #2.5 clk = ~clk;
    tx_abort_cause tx_abort_cause_i (.CLK(clk), .RST(rst), .ADDR(addr), .WR_DATA(wdata),
        .WR_EN(wr), .RD_EN(rd), .RD_DATA(rdata), .SLV_TX_ACTIVE(slv), .MST_ACTIVE(mst),
        .BUS_MISMATCH(mis), .SLV_RD_REQ(sreq), .TXFIFO_EMPTY(empty), .MST_START(start),
        .MST_RD(mrd), .ADDR_10BIT(a10), .MASTER_EN(men), .RESTART_EN(ren),
        .TX_ABORT(abrt), .TXFIFO_FLUSH(flush), .IRQ(irq));
    remote_party remote_party_i (.CLK(clk), .RST(rst), .LOSE(lose), .READ(rreq),
        .BUS_MISMATCH(mis), .SLV_RD_REQ(sreq));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] e);
        n_tests++;
        if (got !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, rdata, e);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        error_cnt++;
        finish_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFF_CONFIG, {30'h0, CFG_RESET}, "config");
        chk("cfg pins reset", {ren, men}, CFG_RESET);
        rd_chk(OFF_CAUSE, 32'h0, "cause reset");
        wr_reg(OFF_CAUSE, 32'h7c00);
        rd_chk(OFF_CAUSE, 32'h0, "cause ro");
        rd_chk(8'h1c, 32'h0, "unmapped");
        wr_reg(OFF_INT_ENABLE, 32'h1);
        for (int i = 0; i < 8; i++) begin
            s = STIM[i];
            wr_reg(OFF_CONFIG, {30'h0, s[9:8]});
            @(posedge clk);
            {slv, mst, empty, mrd, a10, lose, rreq, start} <= s[7:0];
            nf = 0;
            // Window covers both direct and partner-delayed events
            repeat (4) begin
                @(posedge clk);
                {lose, rreq, start} <= 3'h0;
                #1 nf += (flush === 1'b1);
            end
            chk("flush", nf, EXP[i] != 0);
            chk("abort", abrt, EXP[i] != 0);
            chk("irq", irq, EXP[i] != 0);
            chk("cfg pins", {ren, men}, s[9:8]);
            nab += (EXP[i] != 0);
            repeat (5) @(posedge clk);
            rd_chk(OFF_CAUSE, {17'h0, EXP[i], 10'h0}, "cause");
            rd_chk(OFF_INT_STATUS, {30'h0, {2{EXP[i] != 5'h00}}}, "int status");
            wr_reg(OFF_INT_CLEAR, 32'h3);
            wr_reg(OFF_ABORT_CLR, 32'h1);
            rd_chk(OFF_CAUSE, 32'h0, "cleared");
            chk("irq off", irq, 1'b0);
            chk("abort off", abrt, 1'b0);
        end
        rd_chk(OFF_ABORT_CNT, nab, "abort count");
        wr_reg(OFF_ABORT_CNT, 32'h0);
        rd_chk(OFF_ABORT_CNT, 32'h0, "count clear");
        // A cause landing in the clearing cycle must survive it
        wr_reg(OFF_CONFIG, 32'h0);
        @(posedge clk);
        addr  <= OFF_ABORT_CLR;
        wr    <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        start <= 1'b0;
        #1 chk("abort race", abrt, 1'b1);
        rd_chk(OFF_CAUSE, 32'h1 << BIT_MST_DIS, "cause race");
        finish_test;
    end
endmodule
`default_nettype wire
